// ==== core/cbg_glue.sv ====
// Operation
// - Divide master clock by nine into two non-overlapping phases.
// - Synchronise ready and reset to the phase clock before the processor.
// - Ready when onboard, or bus granted, external and peripheral ready.
// - Internal reset whenever backplane reset line is low.
// - Power-on clear resets processor, status latch and strobe, baud port and serial clock.
// - Status strobe in first state; latch holds status for the cycle.
// - Onboard select only when top four address bits are zero.
// - Decoder disabled during interrupt acknowledge.
// - Decode uses A10, A11 for memory, A2, A3 for ports, and OR of input and output status.
// - Three ROM selects cover 0 to BFF, each gated with data-in strobe.
// - RAM select for C00 to FFF; RAM addressed by low eight bits.
// - Ports 0 to 3 select serial controller; A0 picks register.
// - Ports 4 to 7 select baud rate port.
// - Ports 8 to B select real-time clock logic.
// - Ports C to F select single-step logic.
// - Priority encoder turns highest request into restart 0 to 7.
// - Serial clock is phase two halved, then divided by two times one more than the baud port value.
// - Tick flip-flop set on each rising mains reference edge.
// - Output write to tick port clears the tick flip-flop.
// - Jumper routes tick into the interrupt requests.
`timescale 1ns/1ps
`default_nettype none
module cbg_glue (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              backplane_reset_n,
  input  wire logic              bus_granted,
  input  wire logic              external_ready,
  input  wire logic              peripheral_ready,
  input  wire logic              mains_ref,
  input  wire logic              tick_jumper,
  input  wire logic [7:0]        int_req,
  input  wire logic              cpu_sync,
  input  wire logic              cpu_dbin,
  input  wire logic              cpu_wr_n,
  input  wire logic [15:0]       cpu_addr,
  input  wire logic [7:0]        cpu_dout,
  input  wire logic [7:0]        bus_din,
  output var  logic              phi1,
  output var  logic              phi2,
  output var  logic              cpu_ready,
  output var  logic              cpu_reset,
  output var  logic              power_on_clear,
  output var  logic              system_status_strobe,
  output var  logic [7:0]        status_q_out,
  output var  logic              onboard_select_n,
  output var  cbg_pkg::cbg_sel_type sel,
  output var  logic [2:0]        rom_cs,
  output var  logic [7:0]        ram_addr,
  output var  logic              serial_reg_sel,
  output var  logic [7:0]        cpu_din,
  output var  logic [7:0]        baud_q_out,
  output var  logic              serial_clk,
  output var  logic              tick_q_out,
  output var  logic              cpu_int
);
  import cbg_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [4:0] async_bus;
  logic [4:0] sync_bus;
  logic       rst_lvl;
  logic       rdy_bg;
  logic       rdy_ext;
  logic       rdy_per;
  logic       mains_s;
  assign async_bus = {~backplane_reset_n, bus_granted, external_ready,
                      peripheral_ready, mains_ref};

  cbg_sync2 #(.W(5)) u_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in (async_bus),
    .sync_out (sync_bus)
  );

  assign {rst_lvl, rdy_bg, rdy_ext, rdy_per, mains_s} = sync_bus;

  // ---------------------------------------------------------------
  // Divide-by-nine and two phases
  // ---------------------------------------------------------------
  logic [3:0] div_q;
  logic [3:0] div_d;
  logic       phi1_q;
  logic       phi1_d;
  logic       phi2_q;
  logic       phi2_d;
  logic       phi2_fall;
  always_comb begin
    div_d  = (div_q == CLK_DIV_LAST) ? '0 : div_q + 4'h1;
    // Disjoint slot ranges and the one gap slot after phase two keep them from overlapping
    phi1_d = (div_d >= PH1_START) && (div_d <= PH1_END);
    phi2_d = (div_d >= PH2_START) && (div_d <= PH2_END);
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_q  <= '0;
      phi1_q <= 1'b0;
      phi2_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      phi1_q <= phi1_d;
      phi2_q <= phi2_d;
    end
  end

  // Gap slot follows the last phase-two slot, so it marks phase two falling
  assign phi2_fall = (div_q == CLK_DIV_LAST);
  assign phi1      = phi1_q;
  assign phi2      = phi2_q;

  // ---------------------------------------------------------------
  // Ready, reset, status strobe
  // ---------------------------------------------------------------
  logic       ready_q;
  logic       ready_d;
  logic       reset_q;
  logic       reset_d;
  logic       strobe_q;
  logic       strobe_d;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic       phase_edge;
  logic       onboard;
  // Update only at the end of phase two, as the processor samples then
  assign phase_edge = (div_q == PH2_END);
  assign onboard    = (cpu_addr[ADDR_HI_MSB:ADDR_HI_LSB] == 4'h0);

  always_comb begin
    ready_d  = ready_q;
    reset_d  = reset_q;
    strobe_d = 1'b0;
    status_d = status_q;
    if (phase_edge) begin
      ready_d  = onboard | (rdy_bg & rdy_ext & rdy_per);
      reset_d  = rst_lvl;
      strobe_d = cpu_sync;
    end
    if (strobe_q) begin
      status_d = cpu_dout;
    end
    if (reset_q) begin
      strobe_d = 1'b0;
      status_d = '0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ready_q  <= 1'b0;
      reset_q  <= 1'b1;
      strobe_q <= 1'b0;
      status_q <= '0;
    end else begin
      ready_q  <= ready_d;
      reset_q  <= reset_d;
      strobe_q <= strobe_d;
      status_q <= status_d;
    end
  end

  assign cpu_ready            = ready_q;
  assign cpu_reset            = reset_q;
  assign power_on_clear       = reset_q;
  assign system_status_strobe = strobe_q;
  assign status_q_out         = status_q;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic io_cycle;
  logic inta;
  logic dec_en;
  assign io_cycle = status_q[ST_INP] | status_q[ST_OUT];
  assign inta     = status_q[ST_INTA];
  assign dec_en   = onboard & ~inta;
  always_comb begin
    sel = '0;
    sel.tick_port_select_n = 1'b1;
    if (dec_en && !io_cycle) begin
      case (cpu_addr[ADDR_SEL_MSB:ADDR_SEL_LSB])
        SEL_ROM0: sel.rom_select_0 = 1'b1;
        SEL_ROM1: sel.rom_select_1 = 1'b1;
        SEL_ROM2: sel.rom_select_2 = 1'b1;
        SEL_RAM:  sel.ram_select   = 1'b1;
        default:  sel.ram_select   = 1'b0;
      endcase
    end else if (dec_en && io_cycle) begin
      case (cpu_addr[PORT_SEL_MSB:PORT_SEL_LSB])
        SEL_SER:  sel.serial_port_select = 1'b1;
        SEL_BAUD: sel.baud_port_select   = 1'b1;
        SEL_TICK: sel.tick_port_select_n = 1'b0;
        SEL_STEP: sel.single_step_select = 1'b1;
        default:  sel.single_step_select = 1'b0;
      endcase
    end
  end

  assign onboard_select_n = ~onboard;
  assign rom_cs = {sel.rom_select_2, sel.rom_select_1, sel.rom_select_0}
                  & {3{cpu_dbin}};
  assign ram_addr       = cpu_addr[7:0];
  assign serial_reg_sel = cpu_addr[0];

  // ---------------------------------------------------------------
  // Baud port and serial clock
  // ---------------------------------------------------------------
  logic [7:0] baud_q;
  logic [7:0] baud_d;
  logic       half_q;
  logic       half_d;
  logic [7:0] bcnt_q;
  logic [7:0] bcnt_d;
  logic       sclk_q;
  logic       sclk_d;
  always_comb begin
    baud_d = baud_q;
    half_d = half_q;
    bcnt_d = bcnt_q;
    sclk_d = sclk_q;
    if (sel.baud_port_select && !cpu_wr_n) begin
      baud_d = cpu_dout;
    end
    if (phi2_fall) begin
      half_d = ~half_q;
      // Divider steps on each rising edge of the halved phase
      if (!half_q) begin
        if (bcnt_q >= baud_q) begin
          bcnt_d = '0;
          sclk_d = ~sclk_q;
        end else begin
          bcnt_d = bcnt_q + 8'h01;
        end
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst || reset_q) begin
      baud_q <= '0;
      half_q <= 1'b0;
      bcnt_q <= '0;
      sclk_q <= 1'b0;
    end else begin
      baud_q <= baud_d;
      half_q <= half_d;
      bcnt_q <= bcnt_d;
      sclk_q <= sclk_d;
    end
  end

  assign baud_q_out = baud_q;
  assign serial_clk = sclk_q;

  // ---------------------------------------------------------------
  // Real-time tick
  // ---------------------------------------------------------------
  logic mains_prev_q;
  logic mains_prev_d;
  logic tick_q;
  logic tick_d;
  logic tick_clr;
  assign tick_clr = ~sel.tick_port_select_n & ~cpu_wr_n;

  always_comb begin
    mains_prev_d = mains_s;
    tick_d       = tick_q;
    if (tick_clr) begin
      tick_d = 1'b0;
    end
    // A new edge wins over a clear in the same cycle
    if (mains_s && !mains_prev_q) begin
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mains_prev_q <= 1'b0;
      tick_q       <= 1'b0;
    end else begin
      mains_prev_q <= mains_prev_d;
      tick_q       <= tick_d;
    end
  end

  assign tick_q_out = tick_q;

  // ---------------------------------------------------------------
  // Priority encoder and data-in mux
  // ---------------------------------------------------------------
  logic [7:0] req_all;
  logic [2:0] prio;
  logic [7:0] din_q;
  logic [7:0] din_d;
  assign req_all = {int_req[7:1], int_req[0] | (tick_jumper & tick_q)};

  // Later requests override earlier ones, so the highest index wins
  always_comb begin
    prio  = '0;
    din_d = bus_din;
    for (int i = 0; i < 8; i++) begin
      if (req_all[i]) begin
        prio = 3'(i);
      end
    end
    if (inta) begin
      din_d = RST_BASE | {2'h0, prio, 3'h0};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      din_q <= '0;
    end else begin
      din_q <= din_d;
    end
  end

  assign cpu_din = din_q;
  assign cpu_int = |req_all;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_div9;
    @(posedge ref_clk) disable iff (sys_rst)
      (div_q == CLK_DIV_LAST) |=> (div_q == 4'h0) ##8 (div_q == CLK_DIV_LAST);
  endproperty
  a_div9: assert property (p_div9) else $error("clock divide not nine");
  property p_nonoverlap;
    @(posedge ref_clk) disable iff (sys_rst) !(phi1 && phi2);
  endproperty
  a_nonoverlap: assert property (p_nonoverlap) else $error("phases overlap");
  property p_inta_nosel;
    @(posedge ref_clk) disable iff (sys_rst) inta |-> (rom_cs == 3'b000 && !sel.ram_select);
  endproperty
  a_inta_nosel: assert property (p_inta_nosel) else $error("select in acknowledge");
  property p_offboard;
    @(posedge ref_clk) disable iff (sys_rst) !onboard |-> (sel.tick_port_select_n && !sel.ram_select);
  endproperty
  a_offboard: assert property (p_offboard) else $error("select while off board");
  property p_tick_set;
    @(posedge ref_clk) disable iff (sys_rst) (mains_s && !mains_prev_q) |=> tick_q;
  endproperty
  a_tick_set: assert property (p_tick_set) else $error("tick not set");
  property p_tick_hold;
    @(posedge ref_clk) disable iff (sys_rst) (tick_q && !tick_clr) |=> tick_q;
  endproperty
  a_tick_hold: assert property (p_tick_hold) else $error("tick lost");
  property p_strobe_latch;
    @(posedge ref_clk) disable iff (sys_rst || reset_q)
      strobe_q |=> (status_q == $past(cpu_dout));
  endproperty
  a_strobe_latch: assert property (p_strobe_latch) else $error("status not latched");
  property p_ready;
    @(posedge ref_clk) disable iff (sys_rst)
      (phase_edge && onboard) |=> cpu_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("onboard not ready");

endmodule : cbg_glue
`default_nettype wire

// ==== core/cbg_pkg.sv ====
package cbg_pkg;

  // ---------------------------------------------------------------
  // Clock generation
  // ---------------------------------------------------------------
  localparam logic [3:0] CLK_DIV_LAST = 4'h8;
  localparam logic [3:0] PH1_START    = 4'h0;
  localparam logic [3:0] PH1_END      = 4'h2;
  localparam logic [3:0] PH2_START    = 4'h3;
  localparam logic [3:0] PH2_END      = 4'h7;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  localparam int ADDR_HI_MSB  = 15;
  localparam int ADDR_HI_LSB  = 12;
  localparam int ADDR_SEL_MSB = 11;
  localparam int ADDR_SEL_LSB = 10;
  localparam int PORT_SEL_MSB = 3;
  localparam int PORT_SEL_LSB = 2;

  localparam logic [1:0] SEL_ROM0 = 2'h0;
  localparam logic [1:0] SEL_ROM1 = 2'h1;
  localparam logic [1:0] SEL_ROM2 = 2'h2;
  localparam logic [1:0] SEL_RAM  = 2'h3;
  localparam logic [1:0] SEL_SER  = 2'h0;
  localparam logic [1:0] SEL_BAUD = 2'h1;
  localparam logic [1:0] SEL_TICK = 2'h2;
  localparam logic [1:0] SEL_STEP = 2'h3;

  // Restart opcode: 11 nnn 111
  localparam logic [7:0] RST_BASE  = 8'hc7;
  localparam int         RST_SHIFT = 3;

  // Status word bit positions
  localparam int ST_INTA = 0;
  localparam int ST_OUT  = 4;
  localparam int ST_INP  = 6;

  typedef struct packed {
    logic rom_select_0;
    logic rom_select_1;
    logic rom_select_2;
    logic ram_select;
    logic serial_port_select;
    logic baud_port_select;
    logic tick_port_select_n;
    logic single_step_select;
  } cbg_sel_type;

endpackage : cbg_pkg

// ==== core/cbg_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbg_sync2 #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : cbg_sync2
`default_nettype wire

// ==== sim/cbg_bus_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Backplane model: off-board reads wait, released data toggles
// ---------------------------------------------------------------
module cbg_bus_model #(
  parameter logic [7:0] DATA = 8'h5a
) (
  input  wire logic       ref_clk,
  input  wire logic [7:0] stall,
  input  wire logic       cpu_dbin,
  input  wire logic       onboard_select_n,
  output var  logic       bus_granted,
  output var  logic       external_ready,
  output var  logic       peripheral_ready,
  output var  logic [7:0] bus_din
);
  logic [7:0] wait_q = 8'h00;
  initial bus_din = 8'h00;
  always @(posedge ref_clk) begin
    if (onboard_select_n && cpu_dbin) begin
      if (wait_q < stall) wait_q <= wait_q + 8'h01;
    end else begin
      wait_q <= 8'h00;
    end
    // Inverted when idle so stale data never passes for valid
    bus_din <= cpu_dbin ? DATA : ~bus_din;
  end
  assign bus_granted      = (wait_q >= stall) && onboard_select_n && cpu_dbin;
  assign external_ready   = bus_granted;
  assign peripheral_ready = bus_granted;
endmodule : cbg_bus_model
`default_nettype wire

// ==== sim/tb_cbg_glue.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_cbg_glue;
  import cbg_pkg::*;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        backplane_reset_n = 1'b1;
  logic        mains_ref = 1'b0;
  logic        tick_jumper = 1'b0;
  logic        cpu_sync = 1'b0;
  logic        cpu_dbin = 1'b0;
  logic        cpu_wr_n = 1'b1;
  logic [7:0]  int_req = 8'h00;
  logic [7:0]  cpu_dout = 8'h00;
  logic [7:0]  stall = 8'h00;
  logic [15:0] cpu_addr = 16'h0000;
  logic        phi1, phi2, cpu_ready, cpu_reset, power_on_clear, system_status_strobe;
  logic        onboard_select_n, serial_reg_sel, serial_clk, tick_q_out, cpu_int;
  logic        bus_granted, external_ready, peripheral_ready;
  logic [7:0]  status_q_out, ram_addr, cpu_din, baud_q_out, bus_din;
  logic [2:0]  rom_cs;
  cbg_sel_type sel;
  int          errors = 0;
  int          comparisons = 0;
  int          cyc = 0;

  cbg_bus_model BUS (.ref_clk, .stall, .cpu_dbin, .onboard_select_n, .bus_granted,
    .external_ready, .peripheral_ready, .bus_din);
  cbg_glue DUT (.ref_clk, .sys_rst, .backplane_reset_n, .bus_granted, .external_ready,
    .peripheral_ready, .mains_ref, .tick_jumper, .int_req, .cpu_sync, .cpu_dbin,
    .cpu_wr_n, .cpu_addr, .cpu_dout, .bus_din, .phi1, .phi2, .cpu_ready, .cpu_reset,
    .power_on_clear, .system_status_strobe, .status_q_out, .onboard_select_n, .sel,
    .rom_cs, .ram_addr, .serial_reg_sel, .cpu_din, .baud_q_out, .serial_clk,
    .tick_q_out, .cpu_int);

  always #20 ref_clk = ~ref_clk;

  // ---------------------------------------------------------------
  // Reporting
  // ---------------------------------------------------------------
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // Processor-side cycles
  // ---------------------------------------------------------------
  task automatic cyc_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc_n

  // Sync held until the strobe shows, since the phase slot is hidden
  task automatic latch(input logic [7:0] st);
    int i;
    @(posedge ref_clk);
    cpu_sync <= 1'b1;
    cpu_dout <= st;
    for (i = 0; i < 20 && system_status_strobe !== 1'b1; i++) @(negedge ref_clk);
    check("strobe", system_status_strobe, 1'b1);
    @(posedge ref_clk);
    cpu_sync <= 1'b0;
    @(negedge ref_clk);
    check("strobe_width", system_status_strobe, 1'b0);
    check("status", status_q_out, st);
  endtask : latch

  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    latch(8'h10);
    @(posedge ref_clk);
    cpu_dbin <= 1'b0;
    cpu_addr <= a;
    cpu_dout <= d;
    cpu_wr_n <= 1'b0;
    @(posedge ref_clk);
    cpu_wr_n <= 1'b1;
  endtask : io_wr

  task automatic dec(input logic [15:0] a, input int k);
    cbg_sel_type e;
    e = '0;
    e.tick_port_select_n = 1'b1;
    case (k)
      0: e.rom_select_0 = 1'b1;
      1: e.rom_select_1 = 1'b1;
      2: e.rom_select_2 = 1'b1;
      3: e.ram_select = 1'b1;
      4: e.serial_port_select = 1'b1;
      5: e.baud_port_select = 1'b1;
      6: e.tick_port_select_n = 1'b0;
      7: e.single_step_select = 1'b1;
      default: ;
    endcase
    @(posedge ref_clk);
    cpu_addr <= a;
    @(negedge ref_clk);
    check("onboard_n", onboard_select_n, a[15:12] != 4'h0);
    check("sel", sel, e);
    check("rom_cs", rom_cs, {e.rom_select_2, e.rom_select_1, e.rom_select_0} & {3{cpu_dbin}});
    check("ram_addr", ram_addr, a[7:0]);
    check("reg_sel", serial_reg_sel, a[0]);
  endtask : dec

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_clock;
    int i, n1 = 0, n2 = 0, nb = 0, nr = 0;
    logic p;
    p = phi1;
    for (i = 0; i < 36; i++) begin
      @(negedge ref_clk);
      n1 += int'(phi1);
      n2 += int'(phi2);
      nb += int'(phi1 & phi2);
      nr += int'(phi1 & !p);
      p = phi1;
    end
    check("phi1_high", n1, 12);
    check("phi2_high", n2, 20);
    check("overlap", nb, 0);
    check("phi1_rises", nr, 4);
  endtask : t_clock

  task automatic t_decode;
    int i;
    @(posedge ref_clk);
    cpu_dbin <= 1'b1;
    latch(8'h80);
    for (i = 0; i < 4; i++) begin
      dec({4'h0, 2'(i), 10'h000}, i);
      dec({4'h0, 2'(i), 10'h3ff}, i);
    end
    dec(16'h1000, 8);
    dec(16'hf000, 8);
    @(posedge ref_clk);
    cpu_dbin <= 1'b0;
    dec(16'h0400, 1);
    latch(8'h40);
    for (i = 0; i < 4; i++) begin
      if (i == 2) latch(8'h10);
      dec({12'h000, 2'(i), 2'(i)}, 4 + i);
    end
    latch(8'h01);
    dec(16'h0c00, 8);
    dec(16'h0008, 8);
    for (i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      int_req <= 8'hff >> (7 - i);
      cyc_n(2);
      check("restart", cpu_din, RST_BASE | 8'(i << RST_SHIFT));
      check("int", cpu_int, 1'b1);
    end
    @(posedge ref_clk);
    int_req <= 8'h00;
    cpu_dbin <= 1'b1;
    latch(8'h80);
    cyc_n(2);
    check("din_bus", cpu_din, 8'h5a);
  endtask : t_decode

  task automatic t_ready;
    int i;
    @(posedge ref_clk);
    stall <= 8'h28;
    cpu_addr <= 16'h0000;
    for (i = 0; i < 30 && cpu_ready !== 1'b1; i++) @(negedge ref_clk);
    check("ready_onboard", cpu_ready, 1'b1);
    @(posedge ref_clk);
    cpu_addr <= 16'h2000;
    cyc_n(20);
    check("ready_wait", cpu_ready, 1'b0);
    for (i = 0; i < 60 && cpu_ready !== 1'b1; i++) @(negedge ref_clk);
    check("ready_bus", cpu_ready, 1'b1);
  endtask : t_ready

  task automatic t_tick;
    @(posedge ref_clk);
    mains_ref <= 1'b1;
    tick_jumper <= 1'b1;
    cyc_n(8);
    check("tick_set", tick_q_out, 1'b1);
    check("tick_int", cpu_int, 1'b1);
    @(posedge ref_clk);
    mains_ref <= 1'b0;
    cyc_n(30);
    check("tick_hold", tick_q_out, 1'b1);
    @(posedge ref_clk);
    tick_jumper <= 1'b0;
    cyc_n(1);
    check("tick_unrouted", cpu_int, 1'b0);
    io_wr(16'h0008, 8'h00);
    cyc_n(2);
    check("tick_clear", tick_q_out, 1'b0);
  endtask : t_tick

  task automatic tog(output int n);
    logic s;
    s = serial_clk;
    for (n = 0; n < 1000 && serial_clk === s; n++) @(negedge ref_clk);
  endtask : tog

  // First two toggles may still run on the old ratio
  task automatic t_baud(input logic [7:0] b);
    int n;
    io_wr(16'h0004, b);
    cyc_n(2);
    check("baud", baud_q_out, b);
    tog(n);
    tog(n);
    tog(n);
    check("ser_period", n, (int'(b) + 1) * 18);
  endtask : t_baud

  task automatic t_reset;
    int i;
    @(posedge ref_clk);
    backplane_reset_n <= 1'b0;
    cyc_n(20);
    check("poc", power_on_clear, 1'b1);
    check("cpu_rst", cpu_reset, 1'b1);
    check("baud_clr", baud_q_out, 8'h00);
    check("status_clr", status_q_out, 8'h00);
    @(posedge ref_clk);
    backplane_reset_n <= 1'b1;
    for (i = 0; i < 30 && power_on_clear !== 1'b0; i++) @(negedge ref_clk);
    check("poc_end", power_on_clear, 1'b0);
    check("cpu_rst_end", cpu_reset, 1'b0);
  endtask : t_reset

  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    cyc_n(30);
    t_clock();
    t_decode();
    t_ready();
    t_tick();
    t_baud(8'h00);
    t_baud(8'h02);
    t_reset();
    end_of_test();
  end
endmodule : tb_cbg_glue
`default_nettype wire
